//--- inc/lcv_regs.svh
// Register offsets, field positions, opcodes and result codes of the link command validator
`ifndef LCV_REGS_SVH
`define LCV_REGS_SVH

// Register byte offsets
`define LCV_ADR_CMD 8'h00
`define LCV_ADR_RESULT 8'h04
`define LCV_ADR_CTRL 8'h08
`define LCV_ADR_STATUS 8'h0C

// Command opcodes
`define LCV_OP_SET_OUTPUT 8'h01
`define LCV_OP_SEND_A 8'h20
`define LCV_OP_SEND_B 8'h21
`define LCV_OP_DUMP 8'h13
`define LCV_OP_OPEN_LINK 8'h14
`define LCV_OP_RESET_INIT 8'h0F

// Result codes
`define LCV_RC_OK 3'b000
`define LCV_RC_FORMAT 3'b010
`define LCV_RC_CANNOT 3'b100

// Command byte fields
`define LCV_LVL_LSB 0
`define LCV_MASK_LSB 4
`define LCV_POLL_BIT 4

// Control register fields
`define LCV_CTRL_ONLINE 0
`define LCV_CTRL_TRANSP 1
`define LCV_CTRL_LEN_LSB 8
`define LCV_CTRL_RESET 32'h0000_0000

// Status register fields
`define LCV_ST_LINK_UP 0
`define LCV_ST_LINK_DOWN 1
`define LCV_ST_TX_DONE 2
`define LCV_ST_ESTAB 3
`define LCV_ST_WAIT 4
`define LCV_ST_NEED_B 5
`define LCV_ST_PIN_LSB 6
`define LCV_ST_PENDING 8

// Saturation limit of statistics counters
`define LCV_CNT_MAX 8'hFF

`endif

//--- inc/lcv_pkg.sv
// Types shared by the link command validator
`default_nettype none
package lcv_pkg;
    // Dump sequencer states, one-hot
    typedef enum logic [1:0] {
        LCV_IDLE = 2'b01,
        LCV_DUMP = 2'b10
    } lcv_dump_state_t;
endpackage
`default_nettype wire

//--- design/lcv_top.sv
// Command decode, validation and execution for the link-layer controller
//
// Contract
// - Set-output command rejected 010 during wait state
// - Output latch loads only when mask bit 1
// - Two latches independent, ignore line state
// - Send-A rejected 010 when offline or waiting
// - Transparent mode: send-A, open-link rejected 010
// - Frame count zero or over length: 010
// - Send-A after link-up refused until send-B
// - Send commands refused 100 without link, except send-B in transparent mode
// - First frame takes poll, later ones 0
// - Send-B accepted after link-up, in transparent
// - Transparent: further sends accepted while busy
// - Send-B rejected 010 when offline or waiting
// - Send-B opcode 21, poll byte, count byte
// - Dump writes counter table, then clears counters
// - Dump rejected 010 only in wait state
// - Statistics counters saturate at 255
// - Open-link rejected 010 when offline or waiting
// - Open-link rejected 100 when link established
// - Open-link sends SABM, posts up or down
// - Reset enters wait; only reset-init leaves it
`default_nettype none
`include "lcv_regs.svh"

module lcv_top
    import lcv_pkg::*;
#(
    parameter int NUM_CNT = 8
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [3:0] WB_SEL_I,
    input wire logic [31:0] WB_DAT_I,
    output logic [31:0] WB_DAT_O,
    output logic WB_ACK_O,
    output logic [1:0] PIN_OUT,
    output logic LINK_OPEN_REQ,
    input wire logic LINK_UP_IN,
    input wire logic LINK_FAIL_IN,
    input wire logic LINK_DROP_IN,
    output logic FRAME_REQ,
    output logic FRAME_POLL,
    input wire logic FRAME_DONE,
    input wire logic [NUM_CNT-1:0] CNT_INC,
    output logic MEM_WE,
    output logic [23:0] MEM_ADDR,
    output logic [7:0] MEM_DATA
);

    // Counter index must fit one byte of address offset
    if (NUM_CNT < 1 || NUM_CNT > 256) begin : g_bad_cnt
        $error("NUM_CNT out of range");
    end

    localparam int IW = (NUM_CNT > 1) ? $clog2(NUM_CNT) : 1;

    // Saturating increment, shared by every counter
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        return (v == `LCV_CNT_MAX) ? v : v + 8'h01;
    endfunction

    // Register offset match
    function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
        return adr == off;
    endfunction

    logic rst_s1;
    logic rst_n;
    logic [31:0] cmd_word;
    logic [2:0] result;
    logic [31:0] ctrl;
    logic waiting;
    logic estab;
    logic open_pending;
    logic need_b;
    logic up_flag;
    logic down_flag;
    logic done_flag;
    logic [15:0] frames_left;
    logic [7:0] cnt [NUM_CNT];
    lcv_dump_state_t dstate;
    logic [IW-1:0] didx;
    logic [23:0] dbase;

    logic bus_req;
    logic wr_cmd;
    logic wr_ctrl;
    logic wr_status;
    logic busy;
    logic [7:0] op;
    logic [7:0] b1;
    logic [7:0] b3;
    logic online;
    logic transp;
    logic [7:0] tbl_len;
    logic [2:0] next_code;
    logic acc_set;
    logic acc_send_a;
    logic acc_send_b;
    logic acc_dump;
    logic acc_open;
    logic acc_init;
    logic [15:0] next_left;
    logic frame_end;
    logic last_done;
    logic dump_last;

    // Reset release through two flops; assertion stays asynchronous
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            rst_s1 <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1 <= 1'b1;
            rst_n <= rst_s1;
        end
    end

    // Bus decode; command writes while a dump runs are dropped
    assign bus_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    assign busy = (dstate == LCV_DUMP);
    assign wr_cmd = bus_req & WB_WE_I & hit(WB_ADR_I, `LCV_ADR_CMD) & WB_SEL_I[0] & ~busy;
    assign wr_ctrl = bus_req & WB_WE_I & hit(WB_ADR_I, `LCV_ADR_CTRL);
    assign wr_status = bus_req & WB_WE_I & hit(WB_ADR_I, `LCV_ADR_STATUS) & WB_SEL_I[0];

    // Command bytes come straight off the write data
    assign op = WB_DAT_I[7:0];
    assign b1 = WB_DAT_I[15:8];
    assign b3 = WB_DAT_I[31:24];
    assign online = ctrl[`LCV_CTRL_ONLINE];
    assign transp = ctrl[`LCV_CTRL_TRANSP];
    assign tbl_len = ctrl[`LCV_CTRL_LEN_LSB +: 8];

    // Validation; checks run in a fixed order so only one code wins
    always_comb begin
        next_code = `LCV_RC_OK;
        acc_set = 1'b0;
        acc_send_a = 1'b0;
        acc_send_b = 1'b0;
        acc_dump = 1'b0;
        acc_open = 1'b0;
        acc_init = 1'b0;
        case (op)
            `LCV_OP_RESET_INIT: begin
                acc_init = 1'b1;
            end
            `LCV_OP_SET_OUTPUT: begin
                if (waiting) next_code = `LCV_RC_FORMAT;
                else acc_set = 1'b1;
            end
            `LCV_OP_SEND_A: begin
                if (waiting || !online) next_code = `LCV_RC_FORMAT;
                else if (transp) next_code = `LCV_RC_FORMAT;
                else if (b3 == 8'h00 || b3 > tbl_len) next_code = `LCV_RC_FORMAT;
                else if (!estab) next_code = `LCV_RC_CANNOT;
                else if (need_b) next_code = `LCV_RC_CANNOT;
                else acc_send_a = 1'b1;
            end
            `LCV_OP_SEND_B: begin
                if (waiting || !online) next_code = `LCV_RC_FORMAT;
                else if (b3 == 8'h00 || b3 > tbl_len) next_code = `LCV_RC_FORMAT;
                else if (!estab && !transp) next_code = `LCV_RC_CANNOT;
                else acc_send_b = 1'b1;
            end
            `LCV_OP_DUMP: begin
                if (waiting) next_code = `LCV_RC_FORMAT;
                else acc_dump = 1'b1;
            end
            `LCV_OP_OPEN_LINK: begin
                if (waiting || !online) next_code = `LCV_RC_FORMAT;
                else if (transp) next_code = `LCV_RC_FORMAT;
                else if (estab || open_pending) next_code = `LCV_RC_CANNOT;
                else acc_open = 1'b1;
            end
            default: begin
                next_code = `LCV_RC_FORMAT;
            end
        endcase
    end

    // Wishbone acknowledge: one cycle after the request, dropped next cycle
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= bus_req;
        end
    end

    // Read data; unmapped offsets read as zero
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            WB_DAT_O <= 32'h0000_0000;
        end else if (bus_req && !WB_WE_I) begin
            if (hit(WB_ADR_I, `LCV_ADR_CMD)) WB_DAT_O <= cmd_word;
            else if (hit(WB_ADR_I, `LCV_ADR_RESULT)) WB_DAT_O <= {28'h000_0000, busy, result};
            else if (hit(WB_ADR_I, `LCV_ADR_CTRL)) WB_DAT_O <= ctrl;
            else if (hit(WB_ADR_I, `LCV_ADR_STATUS)) begin
                WB_DAT_O <= 32'h0000_0000;
                WB_DAT_O[`LCV_ST_LINK_UP] <= up_flag;
                WB_DAT_O[`LCV_ST_LINK_DOWN] <= down_flag;
                WB_DAT_O[`LCV_ST_TX_DONE] <= done_flag;
                WB_DAT_O[`LCV_ST_ESTAB] <= estab;
                WB_DAT_O[`LCV_ST_WAIT] <= waiting;
                WB_DAT_O[`LCV_ST_NEED_B] <= need_b;
                WB_DAT_O[`LCV_ST_PIN_LSB +: 2] <= PIN_OUT;
                WB_DAT_O[`LCV_ST_PENDING] <= open_pending;
            end else WB_DAT_O <= 32'h0000_0000;
        end
    end

    // Last command word and its result code
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            cmd_word <= 32'h0000_0000;
            result <= `LCV_RC_OK;
        end else if (wr_cmd) begin
            cmd_word <= WB_DAT_I;
            result <= next_code;
        end
    end

    // Control register with byte enables
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= `LCV_CTRL_RESET;
        end else if (wr_ctrl) begin
            for (int i = 0; i < 4; i++) begin
                if (WB_SEL_I[i]) ctrl[8*i +: 8] <= WB_DAT_I[8*i +: 8];
            end
        end
    end

    // Wait state: set by every reset, left only by reset-init
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            waiting <= 1'b1;
        end else if (wr_cmd && acc_init) begin
            waiting <= 1'b0;
        end
    end

    // Output latches; each bit follows only its own mask, never the line
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            PIN_OUT <= 2'b00;
        end else if (wr_cmd && acc_set) begin
            for (int i = 0; i < 2; i++) begin
                if (b1[`LCV_MASK_LSB + i]) PIN_OUT[i] <= b1[`LCV_LVL_LSB + i];
            end
        end
    end

    // Link establishment: request pulse, then wait for the outcome
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            LINK_OPEN_REQ <= 1'b0;
            open_pending <= 1'b0;
            estab <= 1'b0;
        end else begin
            LINK_OPEN_REQ <= wr_cmd & acc_open;
            if (wr_cmd && acc_open) open_pending <= 1'b1;
            else if (LINK_UP_IN || LINK_FAIL_IN) open_pending <= 1'b0;
            if (LINK_UP_IN && open_pending) estab <= 1'b1;
            else if (LINK_DROP_IN) estab <= 1'b0;
        end
    end

    // Sticky link events; hardware set beats software clear
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            up_flag <= 1'b0;
            down_flag <= 1'b0;
        end else begin
            if (LINK_UP_IN && open_pending) up_flag <= 1'b1;
            else if (wr_status && WB_DAT_I[`LCV_ST_LINK_UP]) up_flag <= 1'b0;
            if ((LINK_FAIL_IN && open_pending) || (LINK_DROP_IN && estab)) down_flag <= 1'b1;
            else if (wr_status && WB_DAT_I[`LCV_ST_LINK_DOWN]) down_flag <= 1'b0;
        end
    end

    // Send-A stays locked after link-up until a send-B runs; a fresh link-up wins
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            need_b <= 1'b0;
        end else if (LINK_UP_IN && open_pending) begin
            need_b <= 1'b1;
        end else if (wr_cmd && acc_send_b) begin
            need_b <= 1'b0;
        end
    end

    // Frame sequencer; new sends add to the backlog, so no wait on the
    // current frame, and the host knows the table entry is ready
    assign frame_end = FRAME_DONE & FRAME_REQ;
    assign last_done = frame_end & (frames_left == 16'h0001);
    always_comb begin
        next_left = frames_left;
        if (frame_end) next_left = next_left - 16'h0001;
        if (wr_cmd && (acc_send_a || acc_send_b)) next_left = next_left + {8'h00, b3};
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            frames_left <= 16'h0000;
            FRAME_REQ <= 1'b0;
            FRAME_POLL <= 1'b0;
        end else begin
            frames_left <= next_left;
            FRAME_REQ <= (next_left != 16'h0000);
            if (wr_cmd && (acc_send_a || acc_send_b) && (frames_left == 16'h0000 || last_done)) begin
                FRAME_POLL <= b1[`LCV_POLL_BIT];
            end else if (frame_end) begin
                FRAME_POLL <= 1'b0;
            end
        end
    end

    // Transmit-done marks the end of the last queued frame
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            done_flag <= 1'b0;
        end else if (last_done && next_left == 16'h0000) begin
            done_flag <= 1'b1;
        end else if (wr_status && WB_DAT_I[`LCV_ST_TX_DONE]) begin
            done_flag <= 1'b0;
        end
    end

    // Dump sequencer: one byte per cycle to external memory
    assign dump_last = (didx == IW'(NUM_CNT - 1));
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            dstate <= LCV_IDLE;
            didx <= '0;
            dbase <= 24'h00_0000;
        end else begin
            unique case (dstate)
                LCV_IDLE: begin
                    if (wr_cmd && acc_dump) begin
                        dstate <= LCV_DUMP;
                        didx <= '0;
                        dbase <= {b1, WB_DAT_I[23:16], b3}; // High address byte comes first
                    end
                end
                LCV_DUMP: begin
                    if (dump_last) dstate <= LCV_IDLE;
                    else didx <= didx + IW'(1);
                end
            endcase
        end
    end

    // Memory write strobe, address and data from flops
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            MEM_WE <= 1'b0;
            MEM_ADDR <= 24'h00_0000;
            MEM_DATA <= 8'h00;
        end else begin
            MEM_WE <= busy;
            MEM_ADDR <= dbase + 24'(didx);
            MEM_DATA <= cnt[didx];
        end
    end

    // Statistics counters; cleared after the last byte, so counts
    // arriving during a dump once their counter's byte is read are lost by design
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_CNT; i++) cnt[i] <= 8'h00;
        end else begin
            for (int i = 0; i < NUM_CNT; i++) begin
                if (busy && dump_last) cnt[i] <= 8'h00;
                else if (CNT_INC[i]) cnt[i] <= sat_inc(cnt[i]);
            end
        end
    end

endmodule
`default_nettype wire

//--- bench/lcv_top_properties.sv
// Port-level checks of the link command validator
`default_nettype none
`include "lcv_regs.svh"
module lcv_top_properties #(
    parameter int NUM_CNT = 8
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [7:0] WB_ADR_I,
    input wire logic [31:0] WB_DAT_I,
    input wire logic WB_ACK_O,
    input wire logic [1:0] PIN_OUT,
    input wire logic LINK_OPEN_REQ,
    input wire logic FRAME_REQ,
    input wire logic FRAME_POLL,
    input wire logic FRAME_DONE,
    input wire logic MEM_WE,
    input wire logic [23:0] MEM_ADDR
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] wr_op;
    int unsigned burst;
    // Opcode of a command write on the bus, 00 when none
    assign wr_op = (WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == `LCV_ADR_CMD) ? WB_DAT_I[7:0] : 8'h00;
    // Length of the current dump burst
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            burst <= 0;
        end else begin
            burst <= MEM_WE ? burst + 1 : 0;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    sequence s_take;
        WB_CYC_I && WB_STB_I && !WB_ACK_O;
    endsequence
    sequence s_ack_pulse;
        WB_ACK_O ##1 !WB_ACK_O;
    endsequence
    a_ack_once: assert property (s_take |=> s_ack_pulse) else $error("ack is not one pulse");
    a_open_pulse: assert property (LINK_OPEN_REQ |=> !LINK_OPEN_REQ) else $error("open request too long");
    a_open_cause: assert property ($rose(LINK_OPEN_REQ) |-> $past(wr_op) == `LCV_OP_OPEN_LINK)
        else $error("open request without command");
    a_frame_cause: assert property ($rose(FRAME_REQ) |-> $past(wr_op) inside {`LCV_OP_SEND_A, `LCV_OP_SEND_B})
        else $error("frames without send command");
    a_poll_later: assert property (FRAME_DONE && FRAME_REQ |=> !FRAME_POLL) else $error("later frame polls");
    a_dump_len: assert property ($fell(MEM_WE) |-> burst == NUM_CNT) else $error("dump length wrong");
    a_dump_step: assert property (MEM_WE && $past(MEM_WE) |-> MEM_ADDR == $past(MEM_ADDR) + 24'h00_0001)
        else $error("dump address step wrong");
    a_pin_cause: assert property (PIN_OUT != $past(PIN_OUT) |->
        $past(wr_op) == `LCV_OP_SET_OUTPUT || $past(wr_op, 2) == `LCV_OP_SET_OUTPUT)
        else $error("pins moved without command");
endmodule
bind lcv_top lcv_top_properties #(.NUM_CNT(NUM_CNT)) u_props (
    .CLK(CLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
    .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_ACK_O(WB_ACK_O), .PIN_OUT(PIN_OUT),
    .LINK_OPEN_REQ(LINK_OPEN_REQ), .FRAME_REQ(FRAME_REQ), .FRAME_POLL(FRAME_POLL),
    .FRAME_DONE(FRAME_DONE), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR)
);
`default_nettype wire

//--- bench/lcv_link_model.sv
// Behavioural frame engine facing the validator
`default_nettype none
module lcv_link_model (
    input wire logic clk,
    input wire logic open_req,
    input wire logic frame_req,
    input wire logic fail_mode,
    output logic up,
    output logic fail,
    output logic done
);
    timeunit 1ns;
    timeprecision 1ps;
    // One job at a time; frames slow so the first poll bit stays visible
    initial begin
        up = 1'b0;
        fail = 1'b0;
        done = 1'b0;
        forever begin
            @(posedge clk);
            if (open_req === 1'b1) begin
                repeat ($urandom_range(1, 6)) @(posedge clk);
                up <= !fail_mode;
                fail <= fail_mode;
                @(posedge clk);
                up <= 1'b0;
                fail <= 1'b0;
            end else if (frame_req === 1'b1) begin
                repeat ($urandom_range(8, 20)) @(posedge clk);
                done <= 1'b1;
                @(posedge clk);
                done <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- bench/lcv_top_tb_top.sv
// Self-checking bench of the link command validator
`default_nettype none
`include "lcv_regs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module lcv_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK = 1'b0, RSTN = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, drop = 1'b0, fmode = 1'b0;
    logic [7:0] adr = 8'h00, cinc = 8'h00, mdata, len;
    logic [31:0] dat = 32'h0000_0000, dout, rdat;
    logic [23:0] maddr, b;
    logic [1:0] pin, pe;
    logic ack, oreq, freq, fpoll, mwe, up, fail, done, wt, onl, trn, est, needb;
    logic [7:0] mem [logic [23:0]];
    logic [7:0] ops [5] = '{`LCV_OP_SET_OUTPUT, `LCV_OP_SEND_A, `LCV_OP_SEND_B, `LCV_OP_DUMP, `LCV_OP_OPEN_LINK};
    int mismatches = 0, total_checks = 0, n;
    initial forever #12.5 CLK = ~CLK;
    lcv_top #(.NUM_CNT(8)) dut (.CLK(CLK), .RSTN(RSTN), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
        .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dout), .WB_ACK_O(ack), .PIN_OUT(pin),
        .LINK_OPEN_REQ(oreq), .LINK_UP_IN(up), .LINK_FAIL_IN(fail), .LINK_DROP_IN(drop), .FRAME_REQ(freq),
        .FRAME_POLL(fpoll), .FRAME_DONE(done), .CNT_INC(cinc), .MEM_WE(mwe), .MEM_ADDR(maddr), .MEM_DATA(mdata));
    lcv_link_model u_link (.clk(CLK), .open_req(oreq), .frame_req(freq), .fail_mode(fmode), .up(up),
        .fail(fail), .done(done));
    // Memory image of every dump write
    always @(posedge CLK) if (mwe === 1'b1) mem[maddr] = mdata;
    task automatic stop_test;
        if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // Classic single cycle, held until the ack edge
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge CLK); while (ack !== 1'b1);
        rdat = dout;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Busy covers a running dump; the code is read once it ends
    task automatic cmd(input logic [7:0] op, input logic [23:0] arg, input logic [2:0] e);
        bus(1'b1, `LCV_ADR_CMD, {arg, op});
        do bus(1'b0, `LCV_ADR_RESULT, 32'h0000_0000); while (rdat[3] === 1'b1);
        `CHK("result", e, rdat[2:0])
    endtask
    function automatic logic [1:0] pexp(input logic [1:0] o, input logic [1:0] l, input logic [1:0] m);
        return (o & ~m) | (l & m);
    endfunction
    function automatic logic [23:0] dbase(input logic [23:0] a);
        return {a[7:0], a[15:8], a[23:16]};
    endfunction
    // Expected code, checks in the fixed order
    function automatic logic [2:0] exp_rc(input logic [7:0] op, input logic [7:0] c);
        if (wt) return `LCV_RC_FORMAT;
        if (op == `LCV_OP_SET_OUTPUT || op == `LCV_OP_DUMP) return `LCV_RC_OK;
        if (!onl || (trn && op != `LCV_OP_SEND_B)) return `LCV_RC_FORMAT;
        if (op != `LCV_OP_OPEN_LINK && (c == 0 || c > len)) return `LCV_RC_FORMAT;
        if (trn) return `LCV_RC_OK;
        if (op == `LCV_OP_OPEN_LINK ? est : !est) return `LCV_RC_CANNOT;
        if (op == `LCV_OP_SEND_A && needb) return `LCV_RC_CANNOT;
        return `LCV_RC_OK;
    endfunction
    // Host confirms the series from the transmit-done flag
    task automatic wait_frames;
        do @(posedge CLK); while (freq !== 1'b0);
        bus(1'b0, `LCV_ADR_STATUS, 32'h0000_0000);
        `CHK("tx_done", 1'b1, rdat[2])
        bus(1'b1, `LCV_ADR_STATUS, 32'h0000_0004);
    endtask
    // Every command except reset-init once with random operands
    task automatic sweep;
        logic [7:0] c, b1;
        logic [2:0] e;
        foreach (ops[i]) begin
            c = 8'($urandom_range(0, len + 1));
            b1 = 8'($urandom) & 8'h33;
            e = exp_rc(ops[i], c);
            cmd(ops[i], {c, 8'h00, b1}, e);
            if (e == `LCV_RC_OK && ops[i] == `LCV_OP_SET_OUTPUT) pe = pexp(pe, b1[1:0], b1[5:4]);
            `CHK("pins", pe, pin)
            if (e == `LCV_RC_OK && ops[i] inside {`LCV_OP_SEND_A, `LCV_OP_SEND_B}) begin
                `CHK("poll", b1[4], fpoll)
                needb = needb && ops[i] != `LCV_OP_SEND_B;
                wait_frames();
            end
            if (e == `LCV_RC_OK && ops[i] == `LCV_OP_OPEN_LINK) begin
                do bus(1'b0, `LCV_ADR_STATUS, 32'h0000_0000); while (rdat[8] === 1'b1);
                `CHK("up_down", {fmode, !fmode}, rdat[1:0])
                bus(1'b1, `LCV_ADR_STATUS, 32'h0000_0003);
                est = !fmode;
                needb = !fmode;
            end
        end
    endtask
    initial begin
        void'($urandom(32'h8af9_ee81));
        repeat (2) begin
            RSTN <= 1'b0;
            repeat (12) @(posedge CLK);
            RSTN <= 1'b1;
            repeat (3) @(posedge CLK);
            {wt, onl, trn, est, needb, len, pe} = {5'b1_0000, 8'h00, 2'b00};
            bus(1'b0, `LCV_ADR_STATUS, 32'h0000_0000);
            `CHK("wait", 1'b1, rdat[4])
            bus(1'b0, 8'h10, 32'h0000_0000);
            `CHK("unmapped", 32'h0000_0000, rdat)
            sweep();
            cmd(`LCV_OP_RESET_INIT, 24'h00_0000, `LCV_RC_OK);
            wt = 1'b0;
            cmd(8'h7E, 24'h00_0000, `LCV_RC_FORMAT);
            sweep();
            {onl, len} = {1'b1, 8'h03};
            bus(1'b1, `LCV_ADR_CTRL, 32'h0000_0301);
            fmode = 1'b1;
            sweep();
            fmode = 1'b0;
            repeat (4) sweep();
            drop <= 1'b1;
            @(posedge CLK) drop <= 1'b0;
            bus(1'b0, `LCV_ADR_STATUS, 32'h0000_0000);
            `CHK("drop", est, rdat[1])
            bus(1'b1, `LCV_ADR_STATUS, 32'h0000_0002);
            est = 1'b0;
            sweep();
            trn = 1'b1;
            bus(1'b1, `LCV_ADR_CTRL, 32'h0000_0303);
            sweep();
            cmd(`LCV_OP_SEND_B, 24'h02_0000, `LCV_RC_OK);
            cmd(`LCV_OP_SEND_B, 24'h01_0000, `LCV_RC_OK);
            wait_frames();
            // Saturation needs more pulses than the counter holds
            cmd(`LCV_OP_DUMP, 24'h00_0000, `LCV_RC_OK);
            n = $urandom_range(1, 40);
            for (int k = 0; k < 300 + n; k++) begin
                @(posedge CLK) cinc <= (k < 300) ? 8'h01 : 8'h02;
                @(posedge CLK) cinc <= 8'h00;
            end
            b = 24'($urandom);
            for (int k = 0; k < 2; k++) begin
                cmd(`LCV_OP_DUMP, b, `LCV_RC_OK);
                `CHK("cnt0", k ? 8'h00 : 8'hFF, mem[dbase(b)])
                `CHK("cnt1", k ? 8'h00 : 8'(n), mem[dbase(b) + 24'h00_0001])
            end
        end
        stop_test();
    end
    // Cut a hang short
    initial begin
        repeat (80000) @(posedge CLK);
        mismatches++;
        stop_test();
    end
endmodule
`default_nettype wire
